// ### ilc_level_concentrator.sv
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module ilc_level_concentrator
    import ilc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Debug and external pins
    input  wire logic        debug_halt,
    input  wire logic [7:0]  irq_pin,
    // Peripheral module bus
    input  wire logic [7:0]  periph_irq,
    output logic      [1:0]  periph_slot,
    // Core side
    input  wire logic        core_irq_ack,
    output logic             core_irq_req,
    output logic      [7:0]  irq_code
);

    ilc_state_s   st_reg;   // Registered state
    ilc_state_s   st_next;  // Next state
    ilc_periph_if pif ();   // Link to slot scanner

    logic         wr_acc;   // Write taken this edge
    logic         rd_setup; // Setup cycle, read or write
    logic         pit_hit;  // Timer passes zero
    logic         pit_step; // Timer decrements
    logic         hit_a;    // Reference A match
    logic         hit_b;    // Reference B match
    logic         pit_req;  // Timer request
    logic         tb_req;   // Time base request
    logic [7:0]   lvl_in;   // Eight controller levels
    logic [15:0]  active;   // Unmasked pending
    logic [7:0]   code;     // Encoded vector

    // Binary level to one-hot controller input; shared levels land on 7
    function automatic logic [7:0] lvl_onehot(input logic [4:0] lvl);
        logic [7:0] oh;
        oh = 8'h00;
        if (lvl >= ILC_SHARED_LVL)
            oh[7] = 1'b1;
        else
            oh[lvl[2:0]] = 1'b1;
        return oh;
    endfunction

    // Peripheral slot scanner
    ilc_slot_scan u_scan (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .periph_irq (periph_irq),
        .pif        (pif.scan)
    );

    assign pif.mux_en = st_reg.mux_en;

    // Write takes effect only at the access edge with ready high
    assign wr_acc   = psel & penable & pwrite & st_reg.pready;
    assign rd_setup = psel & ~penable;

    // Timer events
    always_comb
    begin
        // Halt control low means debug halt does not stop the count
        pit_step = st_reg.cnt_en & ~(st_reg.halt_ctl & debug_halt);
        pit_hit  = pit_step & (st_reg.count == 16'h0000);
        // Each reference compares on its own, gated by its enable
        hit_a    = st_reg.tb_run & st_reg.ref_a_en & (st_reg.tb_count == st_reg.ref_a);
        hit_b    = st_reg.tb_run & st_reg.ref_b_en & (st_reg.tb_count == st_reg.ref_b);
        // Conditions are ANDed with enables before reaching a level
        pit_req  = st_reg.pit_flag & st_reg.req_en;
        tb_req   = (st_reg.st_a & st_reg.ref_a_en) | (st_reg.st_b & st_reg.ref_b_en);
    end

    // Level gathering and priority encoding
    always_comb
    begin
        // One level per source, however many conditions feed it
        lvl_in = pif.folded
               | ({8{pit_req}} & lvl_onehot(st_reg.pit_level))
               | ({8{tb_req}} & lvl_onehot({st_reg.tb_slot, st_reg.tb_level}));
        active = st_reg.pend & st_reg.mask;
        code   = ILC_NO_CODE;
        // Scan downward so the lowest index is left standing
        for (int i = 15; i >= 0; i--)
        begin
            if (active[i])
                code = {i[5:0], 2'b00};
        end
    end

    // Next state
    always_comb
    begin
        st_next = st_reg;

        // Periodic timer counting and reload
        if (pit_hit)
            st_next.count = st_reg.modulus;
        else if (pit_step)
            st_next.count = st_reg.count - 16'h0001;

        // Time base runs freely while enabled
        if (st_reg.tb_run)
            st_next.tb_count = st_reg.tb_count + 32'h0000_0001;

        // Controller pending: pins at even positions, levels at odd
        for (int k = 0; k < 8; k++)
        begin
            st_next.pend[2 * k]     = irq_pin[k];
            st_next.pend[2 * k + 1] = lvl_in[k];
        end
        st_next.vec = code;

        // Request held off entirely while the core enable is clear
        st_next.irq_out = (|active) & st_reg.ee;

        // Register writes
        if (wr_acc)
        begin
            if (paddr == ILC_OFS_MODULUS)
            begin
                st_next.modulus = pwdata[15:0];
            end
            else if (paddr == ILC_OFS_PSC)
            begin
                st_next.cnt_en    = pwdata[ILC_PSC_CNT_EN];
                st_next.req_en    = pwdata[ILC_PSC_REQ_EN];
                st_next.halt_ctl  = pwdata[ILC_PSC_HALT];
                st_next.pit_level = pwdata[ILC_PSC_LVL_LSB +: 5];
                if (pwdata[ILC_PSC_FLAG])
                    st_next.pit_flag = 1'b0;
            end
            else if (paddr == ILC_OFS_REF_A)
            begin
                st_next.ref_a = pwdata;
            end
            else if (paddr == ILC_OFS_REF_B)
            begin
                st_next.ref_b = pwdata;
            end
            else if (paddr == ILC_OFS_TB_CTL)
            begin
                st_next.ref_a_en = pwdata[ILC_TB_A_EN];
                st_next.ref_b_en = pwdata[ILC_TB_B_EN];
                st_next.tb_run   = pwdata[ILC_TB_RUN];
                st_next.tb_level = pwdata[ILC_TB_LVL_LSB +: 3];
                st_next.tb_slot  = pwdata[ILC_TB_SLOT_LSB +: 2];
                if (pwdata[ILC_TB_A_ST])
                    st_next.st_a = 1'b0;
                if (pwdata[ILC_TB_B_ST])
                    st_next.st_b = 1'b0;
            end
            else if (paddr == ILC_OFS_MASK)
            begin
                st_next.mask = pwdata[15:0];
            end
            else if (paddr == ILC_OFS_CFG)
            begin
                st_next.mux_en = pwdata[ILC_CFG_MUX];
            end
            else if (paddr == ILC_OFS_CORE)
            begin
                st_next.ee = pwdata[ILC_CORE_EE];
            end
        end

        // Hardware sets after the software clear, so a same-cycle event survives
        if (pit_hit)
            st_next.pit_flag = 1'b1;
        if (hit_a)
            st_next.st_a = 1'b1;
        if (hit_b)
            st_next.st_b = 1'b1;

        // Taking the interrupt closes the door until software reopens it
        if (core_irq_ack)
            st_next.ee = 1'b0;

        // APB answer: ready for one cycle after each setup cycle
        st_next.pready = rd_setup;
        if (rd_setup)
        begin
            st_next.prdata  = 32'h0000_0000;
            st_next.pslverr = 1'b0;
            if (paddr == ILC_OFS_MODULUS)
                st_next.prdata[15:0] = st_reg.modulus;
            else if (paddr == ILC_OFS_COUNT)
                st_next.prdata[15:0] = st_reg.count;
            else if (paddr == ILC_OFS_PSC)
            begin
                st_next.prdata[ILC_PSC_CNT_EN]         = st_reg.cnt_en;
                st_next.prdata[ILC_PSC_REQ_EN]         = st_reg.req_en;
                st_next.prdata[ILC_PSC_HALT]           = st_reg.halt_ctl;
                st_next.prdata[ILC_PSC_FLAG]           = st_reg.pit_flag;
                st_next.prdata[ILC_PSC_LVL_LSB +: 5]   = st_reg.pit_level;
            end
            else if (paddr == ILC_OFS_TB_COUNT)
                st_next.prdata = st_reg.tb_count;
            else if (paddr == ILC_OFS_REF_A)
                st_next.prdata = st_reg.ref_a;
            else if (paddr == ILC_OFS_REF_B)
                st_next.prdata = st_reg.ref_b;
            else if (paddr == ILC_OFS_TB_CTL)
            begin
                // Both status bits readable so software can tell which matched
                st_next.prdata[ILC_TB_A_EN]            = st_reg.ref_a_en;
                st_next.prdata[ILC_TB_B_EN]            = st_reg.ref_b_en;
                st_next.prdata[ILC_TB_A_ST]            = st_reg.st_a;
                st_next.prdata[ILC_TB_B_ST]            = st_reg.st_b;
                st_next.prdata[ILC_TB_RUN]             = st_reg.tb_run;
                st_next.prdata[ILC_TB_LVL_LSB +: 3]    = st_reg.tb_level;
                st_next.prdata[ILC_TB_SLOT_LSB +: 2]   = st_reg.tb_slot;
            end
            else if (paddr == ILC_OFS_PEND)
                st_next.prdata[15:0] = st_reg.pend;
            else if (paddr == ILC_OFS_MASK)
                st_next.prdata[15:0] = st_reg.mask;
            else if (paddr == ILC_OFS_VEC)
                st_next.prdata[7:0] = st_reg.vec;
            else if (paddr == ILC_OFS_PPEND)
                st_next.prdata = pif.pend;
            else if (paddr == ILC_OFS_CFG)
                st_next.prdata[ILC_CFG_MUX] = st_reg.mux_en;
            else if (paddr == ILC_OFS_CORE)
                st_next.prdata[ILC_CORE_EE] = st_reg.ee;
            else
                st_next.pslverr = 1'b1;  // Unmapped address
        end
        else if (!psel)
        begin
            // Idle bus shows no stale error
            st_next.pslverr = 1'b0;
        end
    end

    // State register; reads of read-only offsets are ignored on write
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st_reg      <= '0;
            st_reg.mask <= ILC_MASK_RESET;
            st_reg.vec  <= ILC_NO_CODE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops
    assign prdata       = st_reg.prdata;
    assign pready       = st_reg.pready;
    assign pslverr      = st_reg.pslverr;
    assign core_irq_req = st_reg.irq_out;
    assign irq_code     = st_reg.vec;
    assign periph_slot  = pif.slot;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    chk_timer_reload: assert property (pit_hit |=> st_reg.count == $past(st_reg.modulus))
        else $error("timer did not reload modulus");
    chk_timer_flag: assert property (pit_hit && st_reg.pit_level < ILC_SHARED_LVL |=>
        st_reg.pit_flag ##1 (st_reg.pend[{st_reg.pit_level[2:0], 1'b1}] || !st_reg.req_en
        || $changed(st_reg.pit_level)))
        else $error("timer zero did not raise flag and level");
    chk_flag_sticky: assert property (st_reg.pit_flag && !(wr_acc && paddr == ILC_OFS_PSC && pwdata[ILC_PSC_FLAG]) |=> st_reg.pit_flag)
        else $error("timer flag cleared without write one");
    chk_halt_counts: assert property (st_reg.cnt_en && !st_reg.halt_ctl && st_reg.count > 16'h0001 |=> st_reg.count == $past(st_reg.count) - 16'h0001)
        else $error("timer stopped while halt control is zero");
    chk_ee_gate: assert property (!st_reg.ee |=> !core_irq_req)
        else $error("core request while external enable clear");
    chk_ack_clear: assert property (core_irq_ack |=> !st_reg.ee [*2] or ##1 (wr_acc && paddr == ILC_OFS_CORE))
        else $error("acknowledge did not clear external enable");
    chk_mask_reset: assert property ($past(sys_rst) |-> st_reg.mask == 16'h0000)
        else $error("mask not cleared by reset");
    chk_vec_idle: assert property ((st_reg.pend & st_reg.mask) == 16'h0000 |=> irq_code == 8'h3C)
        else $error("idle vector code wrong");
    chk_vec_lowest: assert property (st_reg.pend[1] && st_reg.mask[1] && !(st_reg.pend[0] && st_reg.mask[0]) |=> irq_code == 8'h04)
        else $error("lower level did not win");
    chk_tb_match: assert property (hit_a |=> st_reg.st_a)
        else $error("reference A match not flagged");

endmodule // ilc_level_concentrator

// ### ilc_pkg.sv
package ilc_pkg;

    // APB register byte offsets
    localparam logic [7:0] ILC_OFS_MODULUS  = 8'h00;  // Timer reload value
    localparam logic [7:0] ILC_OFS_COUNT    = 8'h04;  // Timer count, read only
    localparam logic [7:0] ILC_OFS_PSC      = 8'h08;  // Timer status and control
    localparam logic [7:0] ILC_OFS_TB_COUNT = 8'h0C;  // Time base count, read only
    localparam logic [7:0] ILC_OFS_REF_A    = 8'h10;  // Time base reference A
    localparam logic [7:0] ILC_OFS_REF_B    = 8'h14;  // Time base reference B
    localparam logic [7:0] ILC_OFS_TB_CTL   = 8'h18;  // Time base control and status
    localparam logic [7:0] ILC_OFS_PEND     = 8'h1C;  // Controller pending, read only
    localparam logic [7:0] ILC_OFS_MASK     = 8'h20;  // Controller mask
    localparam logic [7:0] ILC_OFS_VEC      = 8'h24;  // Controller vector, read only
    localparam logic [7:0] ILC_OFS_PPEND    = 8'h28;  // Peripheral level pending
    localparam logic [7:0] ILC_OFS_CFG      = 8'h2C;  // Bridge module config
    localparam logic [7:0] ILC_OFS_CORE     = 8'h30;  // Core external irq enable

    // Timer status and control fields
    localparam int ILC_PSC_CNT_EN  = 0;  // Count enable
    localparam int ILC_PSC_REQ_EN  = 1;  // Request enable
    localparam int ILC_PSC_HALT    = 2;  // Halt control under debug
    localparam int ILC_PSC_FLAG    = 3;  // Status flag, write one to clear
    localparam int ILC_PSC_LVL_LSB = 8;  // 5-bit binary level field

    // Time base control fields
    localparam int ILC_TB_A_EN     = 0;  // Reference A enable
    localparam int ILC_TB_B_EN     = 1;  // Reference B enable
    localparam int ILC_TB_A_ST     = 2;  // Reference A status, W1C
    localparam int ILC_TB_B_ST     = 3;  // Reference B status, W1C
    localparam int ILC_TB_RUN      = 4;  // Time base count enable
    localparam int ILC_TB_LVL_LSB  = 8;  // 3-bit level field
    localparam int ILC_TB_SLOT_LSB = 12; // 2-bit slot field

    // Config and core fields
    localparam int ILC_CFG_MUX     = 0;  // Level multiplex control
    localparam int ILC_CORE_EE     = 0;  // Core external irq enable

    // Reset values and codes
    localparam logic [15:0] ILC_MASK_RESET = 16'h0000;  // All sources masked
    localparam logic [7:0]  ILC_NO_CODE    = 8'h3C;     // Code when nothing pending
    localparam logic [4:0]  ILC_SHARED_LVL = 5'h07;     // First shared level
    localparam logic [1:0]  ILC_LAST_SLOT  = 2'h3;      // Last time slot

    // Whole state of the top module
    typedef struct packed {
        logic [15:0] modulus;    // Timer reload value
        logic [15:0] count;      // Timer down counter
        logic        cnt_en;     // Timer count enable
        logic        req_en;     // Timer request enable
        logic        halt_ctl;   // Stop under debug halt
        logic        pit_flag;   // Timer status flag
        logic [4:0]  pit_level;  // Timer level, binary
        logic [31:0] tb_count;   // Time base counter
        logic [31:0] ref_a;      // Reference A
        logic [31:0] ref_b;      // Reference B
        logic        ref_a_en;   // Reference A enable
        logic        ref_b_en;   // Reference B enable
        logic        st_a;       // Reference A status
        logic        st_b;       // Reference B status
        logic        tb_run;     // Time base running
        logic [2:0]  tb_level;   // Time base level field
        logic [1:0]  tb_slot;    // Time base slot field
        logic [15:0] pend;       // Controller pending
        logic [15:0] mask;       // Controller mask
        logic [7:0]  vec;        // Controller vector code
        logic        mux_en;     // Level multiplex enable
        logic        ee;         // Core external irq enable
        logic        irq_out;    // Request to core
        logic        pready;     // APB ready
        logic [31:0] prdata;     // APB read data
        logic        pslverr;    // APB error
    } ilc_state_s;

    // Scanner state
    typedef struct packed {
        logic [1:0]  slot;       // Current time slot
        logic [31:0] pend;       // Per-level pending
        logic [7:0]  folded;     // Reduced eight levels
    } ilc_scan_s;

endpackage

// ### ilc_periph_if.sv
`timescale 1ns/10ps
interface ilc_periph_if;
    logic [1:0]  slot;    // Slot being sampled
    logic [31:0] pend;    // Peripheral level pending
    logic [7:0]  folded;  // Eight reduced levels
    logic        mux_en;  // Fold levels 8 to 31 onto 7

    // Scanner side
    modport scan (output slot, output pend, output folded, input mux_en);
    // Controller side
    modport ctrl (input slot, input pend, input folded, output mux_en);
endinterface

// ### ilc_slot_scan.sv
`timescale 1ns/10ps
module ilc_slot_scan
    import ilc_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // Peripheral request lines for the current slot
    input  wire logic [7:0] periph_irq,
    // Toward the controller
    ilc_periph_if.scan      pif
);

    ilc_scan_s sc_reg;   // Registered state
    ilc_scan_s sc_next;  // Next state

    // Slot rotation, sampling and folding
    always_comb
    begin
        sc_next = sc_reg;
        // Walk all four slots without stopping
        sc_next.slot = sc_reg.slot + 2'h1;
        // Slot s, value v lands on level 8*s+v; a dropped line clears
        for (int v = 0; v < 8; v++)
        begin
            sc_next.pend[{sc_reg.slot, v[2:0]}] = periph_irq[v];
        end
        // Levels 0 to 6 pass straight through
        sc_next.folded = {1'b0, sc_reg.pend[6:0]};
        if (pif.mux_en)
        begin
            // Shared level gathers everything from 7 up
            sc_next.folded[7] = |sc_reg.pend[31:7];
        end
        else
        begin
            // Without multiplexing only level 7 itself gets through
            sc_next.folded[7] = sc_reg.pend[7];
        end
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            sc_reg <= '0;
        else
            sc_reg <= sc_next;
    end

    assign pif.slot   = sc_reg.slot;
    assign pif.pend   = sc_reg.pend;
    assign pif.folded = sc_reg.folded;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    chk_slot_rotate: assert property (sc_reg.slot == ILC_LAST_SLOT |=> sc_reg.slot == 2'h0 ##1 sc_reg.slot == 2'h1)
        else $error("slot rotation broken");
    chk_level_sample: assert property (##1 sc_reg.pend[{$past(sc_reg.slot), 3'h2}] == $past(periph_irq[2]))
        else $error("peripheral level not sampled into its slot");

endmodule // ilc_slot_scan

// ### ilc_periph_model.sv
`timescale 1ns/10ps
module ilc_periph_model
    import ilc_pkg::*;
(
    // Levels the peripherals request
    input  wire logic [31:0] levels,
    // Slot shown by the concentrator
    input  wire logic [1:0]  periph_slot,
    // Lines of the shown slot
    output logic      [7:0]  periph_irq
);
    // Only the shown slot is presented, so stale slots never leak
    assign periph_irq = levels[{periph_slot, 3'b000} +: 8];
endmodule // ilc_periph_model

// ### tb.sv
`timescale 1ns/10ps
module tb
    import ilc_pkg::*;
;
    // Bus, pins and core side
    logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic        debug_halt, core_irq_ack, core_irq_req;
    logic [7:0]  paddr, irq_pin, periph_irq, irq_code;
    logic [1:0]  periph_slot;
    logic [31:0] pwdata, prdata, levels, rnd, e;
    logic [32:0] exp_q[$];    // Expected {pslverr, prdata} per read
    int          num_errors, tests_run;

    // Design under test
    ilc_level_concentrator dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .debug_halt(debug_halt), .irq_pin(irq_pin),
        .periph_irq(periph_irq), .periph_slot(periph_slot), .core_irq_ack(core_irq_ack),
        .core_irq_req(core_irq_req), .irq_code(irq_code));
    // Peripheral side
    ilc_periph_model peri (.levels(levels), .periph_slot(periph_slot),
        .periph_irq(periph_irq));

    // Clock, 5 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Compare and count
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic end_sim();
        if (num_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Fixed-seed xorshift
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // One APB transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Hold the access until ready; only the watchdog ends a hang
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    // Note the expectation, then read
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic err = 1'b0);
        exp_q.push_back({err, v});
        xfer(1'b0, a, 32'h0);
    endtask

    // Read results taken at the sampling edge
    always @(posedge sys_clk)
    begin
        if (psel && penable && !pwrite && pready === 1'b1)
            chk({pslverr, prdata}, exp_q.pop_front());
    end

    // Main sequence; debug halt held high throughout
    initial
    begin
        {sys_rst, debug_halt} = 2'b11;
        {psel, penable, pwrite, core_irq_ack} = 4'h0;
        {paddr, irq_pin, pwdata, levels} = 80'h0;
        {num_errors, tests_run} = 64'h0;
        rnd = 32'hEBD2;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(ILC_OFS_MASK, 32'h0);
        rd(ILC_OFS_PSC, 32'h0);
        wr(ILC_OFS_VEC, 32'h0);
        rd(ILC_OFS_VEC, 32'h3C);
        chk({25'h0, irq_code}, 33'h3C);
        rd(8'h40, 32'h0, 1'b1);
        // Random levels, folding off then on
        for (int m = 0; m < 2; m++)
        begin
            rnd = xs(rnd);
            wr(ILC_OFS_CFG, 32'(m));
            levels <= rnd;
            repeat (8) @(posedge sys_clk);
            e = 32'h0;
            for (int k = 0; k < 7; k++)
                e[2*k+1] = rnd[k];
            e[15] = (m == 1) ? |rnd[31:7] : rnd[7];
            rd(ILC_OFS_PPEND, rnd);
            rd(ILC_OFS_PEND, e);
        end
        // Level 0 beats pin 1, then pin 1 alone
        levels <= 32'h1;
        irq_pin <= 8'h02;
        wr(ILC_OFS_MASK, 32'hFFFF);
        repeat (8) @(posedge sys_clk);
        rd(ILC_OFS_VEC, 32'h04);
        levels <= 32'h0;
        repeat (8) @(posedge sys_clk);
        rd(ILC_OFS_VEC, 32'h08);
        rd(ILC_OFS_PPEND, 32'h0);
        irq_pin <= 8'h00;
        // Timer on level 2 keeps counting under halt and reloads
        wr(ILC_OFS_MODULUS, 32'h5);
        wr(ILC_OFS_MASK, 32'h20);
        wr(ILC_OFS_PSC, 32'h203);
        repeat (20) @(posedge sys_clk);
        wr(ILC_OFS_PSC, 32'h20B);
        repeat (20) @(posedge sys_clk);
        rd(ILC_OFS_PSC, 32'h20B);
        rd(ILC_OFS_VEC, 32'h14);
        chk({25'h0, irq_code}, 33'h14);
        chk({32'h0, core_irq_req}, 33'h0);
        wr(ILC_OFS_CORE, 32'h1);
        repeat (3) @(posedge sys_clk);
        chk({32'h0, core_irq_req}, 33'h1);
        core_irq_ack <= 1'b1;
        @(posedge sys_clk);
        core_irq_ack <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({32'h0, core_irq_req}, 33'h0);
        rd(ILC_OFS_CORE, 32'h0);
        // Stopped timer keeps its flag but withdraws the request
        wr(ILC_OFS_PSC, 32'h200);
        repeat (4) @(posedge sys_clk);
        rd(ILC_OFS_PSC, 32'h208);
        rd(ILC_OFS_PEND, 32'h0);
        wr(ILC_OFS_PSC, 32'h208);
        rd(ILC_OFS_PSC, 32'h200);
        // Time base hits both references on slot 1 value 4, level 12, shared on 7
        wr(ILC_OFS_REF_A, 32'h14);
        wr(ILC_OFS_REF_B, 32'h1E);
        wr(ILC_OFS_TB_CTL, 32'h1413);
        repeat (40) @(posedge sys_clk);
        rd(ILC_OFS_TB_CTL, 32'h141F);
        rd(ILC_OFS_PEND, 32'h8000);
        wr(ILC_OFS_TB_CTL, 32'h1417);
        rd(ILC_OFS_TB_CTL, 32'h141B);
        rd(ILC_OFS_PEND, 32'h8000);
        wr(ILC_OFS_TB_CTL, 32'h1408);
        repeat (2) @(posedge sys_clk);
        rd(ILC_OFS_PEND, 32'h0);
        end_sim();
    end

    // Watchdog, far beyond the planned run
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        end_sim();
    end
endmodule // tb
